// >>> rtl/xipr_host_seq.sv
// host sequencer for forced direct-execute exit, rescue and pin reset
// assumes one flash on the link; link_clk_i is a free-running clock
`timescale 1ns/10ps
`default_nettype none

module xipr_host_seq (
  input  wire logic       sys_clk_i,
  input  wire logic       srst_i,
  input  wire logic       link_clk_i,
  input  wire logic       start_i,
  input  wire logic [1:0] op_i,
  input  wire logic [1:0] proto_i,
  input  wire logic       hw_reset_avail_i,
  input  wire logic       power_good_i,
  output logic            busy_o,
  output logic            done_o,
  output logic            access_ok_o,
  output logic            flash_sclk_o,
  output logic            flash_select_n_o,
  output logic            serial_line_0_o,
  output logic            serial_line_0_oe_n_o,
  output logic            serial_line_3_o,
  output logic            serial_line_3_oe_n_o,
  output logic            flash_reset_n_o
);

  xipr_pkg::xipr_state_type state;
  xipr_pkg::xipr_state_type next_state;

  // crossing flops
  logic        pg_s1;
  logic        pg_s2;
  logic        done_s1;
  logic        done_s2;
  logic        done_s3;

  // burst description for the link side
  logic        start_tgl;
  logic [4:0]  burst_clks;
  logic [7:0]  burst_byte;
  logic        burst_is_byte;

  // order, step and timing
  logic [2:0]  step;
  logic [2:0]  last_step;
  logic [1:0]  op;
  logic [1:0]  proto;
  logic [15:0] timer;
  logic        pwr_ready;

  // link side returns
  logic        done_tgl_w;
  logic        sclk_en;
  logic        link_sel_n;
  logic        link_d0;
  logic        link_d3;
  logic        burst_done;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // forced-exit burst length for the protocol the flash currently runs
  function automatic logic [4:0] exit_clks(input logic [1:0] p);
    case (p)
      xipr_pkg::PROTO_QUAD: exit_clks = xipr_pkg::EXIT_CLKS_QUAD;
      xipr_pkg::PROTO_DUAL: exit_clks = xipr_pkg::EXIT_CLKS_DUAL;
      default:              exit_clks = xipr_pkg::EXIT_CLKS_SINGLE;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  // supply flag is a pin, done toggle comes from the link clock
  always_ff @(posedge sys_clk_i) begin
    pg_s1   <= power_good_i;
    pg_s2   <= pg_s1;
    done_s1 <= done_tgl_w;
    done_s2 <= done_s1;
    done_s3 <= done_s2;
  end

  // one change of the returned toggle marks one finished burst
  assign burst_done = done_s2 ^ done_s3;

  // ---------------------------------------------------------------
  // power-up wait
  // ---------------------------------------------------------------
  // hold off all access for the full supply-to-access delay
  logic [15:0] pwr_cnt;
  always_ff @(posedge sys_clk_i) begin
    if (srst_i || !pg_s2) begin
      pwr_cnt   <= 16'h0000;
      pwr_ready <= 1'b0;
    end else if (!pwr_ready) begin
      if (pwr_cnt == 16'(xipr_pkg::POWER_WAIT_CYCLES - 1)) begin
        pwr_ready <= 1'b1;
      end else begin
        pwr_cnt <= pwr_cnt + 16'h0001;
      end
    end
  end

  assign access_ok_o = pwr_ready;

  // ---------------------------------------------------------------
  // step table: what each burst of an operation sends
  // ---------------------------------------------------------------
  // rescue: three ones bursts, then all-ones byte
  // forced exit: one ones burst, then reset-arm and reset-apply
  always_comb begin
    burst_is_byte = 1'b0;
    burst_byte    = xipr_pkg::CMD_ALL_ONES;
    burst_clks    = exit_clks(proto);
    last_step     = 3'h2;

    // rescue: ones bursts of all three exit lengths, then the byte
    if (op == xipr_pkg::OP_RESCUE) begin
      last_step = 3'h3;
      case (step)
        3'h0:    burst_clks = xipr_pkg::EXIT_CLKS_QUAD;
        3'h1:    burst_clks = xipr_pkg::EXIT_CLKS_DUAL;
        3'h2:    burst_clks = xipr_pkg::EXIT_CLKS_SINGLE;
        default: burst_clks = xipr_pkg::BYTE_CLKS;
      endcase
    end else if (step != 3'h0) begin
      // after forced exit the flash is single-line; send full commands
      burst_is_byte = 1'b1;
      burst_clks    = xipr_pkg::BYTE_CLKS;
      burst_byte    = (step == 3'h1) ? xipr_pkg::CMD_RESET_ARM : xipr_pkg::CMD_RESET_APPLY;
    end
  end

  // ---------------------------------------------------------------
  // sequencer state
  // ---------------------------------------------------------------
  // an order runs as a list of bursts:
  // - forced exit: one ones burst sized for the protocol, then
  //   reset-arm and reset-apply as single-line bytes
  // - rescue: ones bursts of all three exit lengths, then one
  //   all-ones byte that leaves any multi-line protocol
  // - pin reset: one low pulse on the pin, select kept high;
  //   without the pin it falls back to a forced exit
  // each burst: launch flips the start toggle, busy waits for
  // the done toggle, gap keeps select high, next moves on
  // the burst description stays still from the step update
  // until the done toggle returns, so the link side reads it
  // without crossing flops of its own
  // limitation: a supply drop mid-order does not abort it
  // next state; a strobe outside idle is never looked at
  always_comb begin
    next_state = state;
    case (state)
      // wait for an order
      xipr_pkg::XIPR_IDLE: begin
        if (start_i) begin
          next_state = xipr_pkg::XIPR_PWR_WAIT;
        end
      end

      // no flash access before the supply wait ends
      xipr_pkg::XIPR_PWR_WAIT: begin
        if (pwr_ready) begin
          if (op == xipr_pkg::OP_HW_RESET && hw_reset_avail_i) begin
            next_state = xipr_pkg::XIPR_HW_RST;
          end else begin
            next_state = xipr_pkg::XIPR_LAUNCH;
          end
        end
      end

      // pin goes low here
      xipr_pkg::XIPR_HW_RST:   next_state = xipr_pkg::XIPR_RST_HOLD;

      // pulse width from the shared timer
      xipr_pkg::XIPR_RST_HOLD: begin
        if (timer == 16'h0000) begin
          next_state = xipr_pkg::XIPR_RST_REL;
        end
      end

      // pin released
      xipr_pkg::XIPR_RST_REL:  next_state = xipr_pkg::XIPR_DONE;

      // start toggle flips here
      xipr_pkg::XIPR_LAUNCH:   next_state = xipr_pkg::XIPR_BUSY;

      // burst runs on the link side
      xipr_pkg::XIPR_BUSY: begin
        if (burst_done) begin
          next_state = xipr_pkg::XIPR_GAP;
        end
      end

      xipr_pkg::XIPR_GAP: begin
        // select stays high for at least the deselect gap
        if (timer == 16'h0000) begin
          next_state = xipr_pkg::XIPR_NEXT;
        end
      end

      // another burst, or the order is complete
      xipr_pkg::XIPR_NEXT: begin
        if (step == last_step) begin
          next_state = xipr_pkg::XIPR_DONE;
        end else begin
          next_state = xipr_pkg::XIPR_LAUNCH;
        end
      end

      // done pulse follows
      xipr_pkg::XIPR_DONE:     next_state = xipr_pkg::XIPR_IDLE;

      // stray codes fall back to idle
      default:                 next_state = xipr_pkg::XIPR_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      state <= xipr_pkg::XIPR_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ---------------------------------------------------------------
  // latched order, step counter and timer
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      op    <= xipr_pkg::OP_FORCE_EXIT;
      proto <= xipr_pkg::PROTO_SINGLE;
      step  <= 3'h0;
      timer <= 16'h0000;
    end else begin
      // an order is latched in idle only
      if (state == xipr_pkg::XIPR_IDLE && start_i) begin
        op    <= op_i;
        proto <= proto_i;
        step  <= 3'h0;
      end

      if (state == xipr_pkg::XIPR_NEXT) begin
        step <= step + 3'h1;
      end

      // one timer serves the deselect gap and the pin pulse
      if (state == xipr_pkg::XIPR_BUSY && burst_done) begin
        // link-domain start latency only lengthens this gap
        timer <= 16'(xipr_pkg::GAP_CYCLES);
      end else if (state == xipr_pkg::XIPR_HW_RST) begin
        timer <= 16'(xipr_pkg::RESET_PULSE_CYCLES);
      end else if (timer != 16'h0000) begin
        timer <= timer - 16'h0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // start toggle toward the link domain
  // ---------------------------------------------------------------
  // burst data are held steady from LAUNCH until the burst is done
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      start_tgl <= 1'b0;
    end else if (state == xipr_pkg::XIPR_LAUNCH) begin
      start_tgl <= ~start_tgl;
    end
  end

  // ---------------------------------------------------------------
  // reset pin: pulsed only while the flash is deselected
  // ---------------------------------------------------------------
  // the hold state is entered only through XIPR_HW_RST from the supply wait, before any burst, so select is high
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      flash_reset_n_o <= 1'b1;
    end else if (state == xipr_pkg::XIPR_HW_RST) begin
      flash_reset_n_o <= 1'b0;
    end else if (state == xipr_pkg::XIPR_RST_REL) begin
      flash_reset_n_o <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // user status
  // ---------------------------------------------------------------
  // done pulse is registered, one cycle after the done state
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      done_o <= 1'b0;
    end else begin
      done_o <= (state == xipr_pkg::XIPR_DONE);
    end
  end

  assign busy_o = (state != xipr_pkg::XIPR_IDLE);

  // ---------------------------------------------------------------
  // link end
  // ---------------------------------------------------------------
  // every ones-burst clock carries line 0 high as the confirm bit; byte bursts shift the command out on line 0
  // confirm-bit high on line 0 ends direct-execute mode
  xipr_link_shifter u_link (
    .link_clk_i      (link_clk_i),
    .srst_i          (srst_i),
    .start_tgl_i     (start_tgl),
    .clks_i          (burst_clks),
    .byte_i          (burst_byte),
    .is_byte_i       (burst_is_byte),
    .done_tgl_o      (done_tgl_w),
    .sclk_en_o       (sclk_en),
    .select_n_o      (link_sel_n),
    .serial_line_0_o (link_d0),
    .serial_line_3_o (link_d3)
  );

  // gated inverted link clock: low outside bursts; enable and data change
  // at the link rising edge while this output is low, so no partial
  // pulses, and the flash samples settled data on its own rising edge
  assign flash_sclk_o         = ~link_clk_i & sclk_en;
  assign flash_select_n_o     = link_sel_n;
  assign serial_line_0_o      = link_d0;
  assign serial_line_3_o      = link_d3;
  // lines 0 and 3 are always driven; line 3 idles high, line 0 idles at the last bit sent
  assign serial_line_0_oe_n_o = 1'b0;
  assign serial_line_3_oe_n_o = 1'b0;

endmodule

`default_nettype wire

// >>> rtl/xipr_pkg.sv
// package for the direct-execute mode and recovery host sequencer
// assumes a 20 MHz system clock and a serial flash on four data lines

package xipr_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int SYS_CLK_HZ              = 20_000_000;
  localparam int SYS_CLK_PERIOD_NS       = 50;
  localparam int POWER_TO_FULL_ACCESS_US = 150;
  localparam int POWER_WAIT_CYCLES       =
    (POWER_TO_FULL_ACCESS_US * (SYS_CLK_HZ / 1_000_000));
  localparam int RESCUE_DESELECT_GAP_NS  = 50;
  localparam int GAP_CYCLES_RAW          =
    (RESCUE_DESELECT_GAP_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  // the gap is at least one cycle; no extra cycles are added for the crossing latency
  localparam int GAP_CYCLES              = (GAP_CYCLES_RAW < 1) ? 1 : GAP_CYCLES_RAW;
  localparam int RESET_PULSE_NS          = 50;
  localparam int RESET_PULSE_CYCLES      =
    (RESET_PULSE_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // burst lengths in link clocks
  // ---------------------------------------------------------------
  localparam logic [4:0] EXIT_CLKS_QUAD   = 5'h07;
  localparam logic [4:0] EXIT_CLKS_DUAL   = 5'h0D;
  localparam logic [4:0] EXIT_CLKS_SINGLE = 5'h19;
  localparam logic [4:0] BYTE_CLKS        = 5'h08;

  // ---------------------------------------------------------------
  // command codes and pattern bytes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_RESET_ARM   = 8'h66;
  localparam logic [7:0] CMD_RESET_APPLY = 8'h99;
  localparam logic [7:0] CMD_ALL_ONES    = 8'hFF;

  // protocol width selectors
  localparam logic [1:0] PROTO_SINGLE = 2'h0;
  localparam logic [1:0] PROTO_DUAL   = 2'h1;
  localparam logic [1:0] PROTO_QUAD   = 2'h2;

  // kinds of link bursts
  typedef enum logic [1:0] {
    XIPR_BURST_ONES = 2'h0,
    XIPR_BURST_BYTE = 2'h1
  } xipr_burst_type;

  // sequencer states, one-hot
  typedef enum logic [9:0] {
    XIPR_IDLE     = 10'h001,
    XIPR_PWR_WAIT = 10'h002,
    XIPR_HW_RST   = 10'h004,
    XIPR_LAUNCH   = 10'h008,
    XIPR_BUSY     = 10'h010,
    XIPR_GAP      = 10'h020,
    XIPR_NEXT     = 10'h040,
    XIPR_DONE     = 10'h080,
    XIPR_RST_HOLD = 10'h100,
    XIPR_RST_REL  = 10'h200
  } xipr_state_type;

  // operations a user may order
  localparam logic [1:0] OP_FORCE_EXIT = 2'h0;
  localparam logic [1:0] OP_RESCUE     = 2'h1;
  localparam logic [1:0] OP_HW_RESET   = 2'h2;

endpackage

// >>> rtl/xipr_link_shifter.sv
// link-side shifter: runs one select-low burst on the link clock
// assumes start toggles arrive from the system domain with stable data
`timescale 1ns/10ps
`default_nettype none

module xipr_link_shifter (
  input  wire logic       link_clk_i,
  input  wire logic       srst_i,
  input  wire logic       start_tgl_i,
  input  wire logic [4:0] clks_i,
  input  wire logic [7:0] byte_i,
  input  wire logic       is_byte_i,
  output logic            done_tgl_o,
  output logic            sclk_en_o,
  output logic            select_n_o,
  output logic            serial_line_0_o,
  output logic            serial_line_3_o
);

  logic       rst_s1;
  logic       rst_s2;
  logic       start_s1;
  logic       start_s2;
  logic       start_s3;
  logic [4:0] remain;
  logic [7:0] shreg;
  logic       ones;

  // ---------------------------------------------------------------
  // crossings into the link domain
  // ---------------------------------------------------------------
  // reset and start toggle each pass two flops before use
  always_ff @(posedge link_clk_i) begin
    rst_s1   <= srst_i;
    rst_s2   <= rst_s1;
    start_s1 <= start_tgl_i;
    start_s2 <= start_s1;
    start_s3 <= start_s2;
  end

  // ---------------------------------------------------------------
  // burst engine
  // ---------------------------------------------------------------
  // data changes on the falling side via this posedge register; the flash
  // samples on the next rising edge of the gated clock
  always_ff @(posedge link_clk_i) begin
    if (rst_s2) begin
      remain          <= 5'h00;
      select_n_o      <= 1'b1;
      sclk_en_o       <= 1'b0;
      serial_line_0_o <= 1'b1;
      serial_line_3_o <= 1'b1;
      shreg           <= 8'hFF;
      ones            <= 1'b1;
      done_tgl_o      <= 1'b0;
    end else if (start_s2 != start_s3) begin
      // data inputs were set before the toggle and are stable here
      remain          <= clks_i;
      select_n_o      <= 1'b0;
      sclk_en_o       <= 1'b1;
      ones            <= ~is_byte_i;
      shreg           <= {byte_i[6:0], 1'b1};
      serial_line_0_o <= is_byte_i ? byte_i[7] : 1'b1;
      serial_line_3_o <= 1'b1;
    end else if (remain != 5'h00) begin
      remain <= remain - 5'h01;
      if (remain == 5'h01) begin
        // deselect before the next clock edge is issued
        sclk_en_o  <= 1'b0;
        select_n_o <= 1'b1;
        done_tgl_o <= ~done_tgl_o;
      end else begin
        serial_line_0_o <= ones ? 1'b1 : shreg[7];
        shreg           <= {shreg[6:0], 1'b1};
      end
    end
  end

endmodule

`default_nettype wire

// >>> test/xipr_host_seq_chk.sv
// checker for the direct-execute exit and rescue host sequencer
// assumes it is bound to xipr_host_seq and sees only its ports
`timescale 1ns/10ps
`default_nettype none

module xipr_host_seq_chk (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic link_clk_i,
  input wire logic power_good_i,
  input wire logic access_ok_o,
  input wire logic flash_sclk_o,
  input wire logic flash_select_n_o,
  input wire logic serial_line_0_oe_n_o,
  input wire logic serial_line_3_o,
  input wire logic serial_line_3_oe_n_o,
  input wire logic flash_reset_n_o
);
  // ---------------------------------------------------------------
  // helper counters
  // ---------------------------------------------------------------
  localparam int PG_MIN = 3000;
  localparam int PG_MAX = 3012;
  int pg_cnt;
  int burst_edges;
  int burst_base;

  // cycles with the supply reported good
  always_ff @(posedge sys_clk_i) begin
    if (srst_i || !power_good_i) begin
      pg_cnt <= 0;
    end else begin
      pg_cnt <= pg_cnt + 1;
    end
  end

  // free-running pulse count; a burst is a difference, so no clear race
  always_ff @(posedge flash_sclk_o) begin
    burst_edges <= burst_edges + 1;
  end

  // count seen when select falls
  always_ff @(negedge flash_select_n_o) begin
    burst_base <= burst_edges;
  end

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  property p_drive_enabled;
    @(posedge sys_clk_i) disable iff (srst_i)
      !serial_line_0_oe_n_o && !serial_line_3_oe_n_o;
  endproperty
  a_drive_enabled: assert property (p_drive_enabled)
    else $error("data lines not driven");

  property p_idle_before_power;
    @(posedge sys_clk_i) disable iff (srst_i)
      !access_ok_o |-> flash_select_n_o && flash_reset_n_o;
  endproperty
  a_idle_before_power: assert property (p_idle_before_power)
    else $error("flash touched before supply wait ended");

  property p_power_delay;
    @(posedge sys_clk_i) disable iff (srst_i)
      $rose(access_ok_o) |-> (pg_cnt >= PG_MIN) && (pg_cnt <= PG_MAX);
  endproperty
  a_power_delay: assert property (p_power_delay)
    else $error("access granted at wrong time after supply good");

  property p_reset_deselected;
    @(posedge sys_clk_i) disable iff (srst_i)
      !flash_reset_n_o |-> flash_select_n_o;
  endproperty
  a_reset_deselected: assert property (p_reset_deselected)
    else $error("reset pin low while selected");

  property p_reset_width;
    @(posedge sys_clk_i) disable iff (srst_i)
      $fell(flash_reset_n_o) |=> !flash_reset_n_o;
  endproperty
  a_reset_width: assert property (p_reset_width)
    else $error("reset pulse too short");

  property p_burst_len;
    @(posedge link_clk_i) disable iff (srst_i)
      $rose(flash_select_n_o) |-> (burst_edges - burst_base) inside {7, 13, 25, 8};
  endproperty
  a_burst_len: assert property (p_burst_len)
    else $error("burst has wrong clock count");

  property p_hold_line_high;
    @(posedge link_clk_i) disable iff (srst_i)
      !flash_select_n_o |-> serial_line_3_o;
  endproperty
  a_hold_line_high: assert property (p_hold_line_high)
    else $error("line 3 low inside a burst");

  property p_deselect_gap;
    @(posedge link_clk_i) disable iff (srst_i)
      $rose(flash_select_n_o) |-> flash_select_n_o [*2];
  endproperty
  a_deselect_gap: assert property (p_deselect_gap)
    else $error("deselect gap too short");
endmodule

bind xipr_host_seq xipr_host_seq_chk i_chk (
  .sys_clk_i(sys_clk_i), .srst_i(srst_i), .link_clk_i(link_clk_i),
  .power_good_i(power_good_i), .access_ok_o(access_ok_o), .flash_sclk_o(flash_sclk_o),
  .flash_select_n_o(flash_select_n_o), .serial_line_0_oe_n_o(serial_line_0_oe_n_o),
  .serial_line_3_o(serial_line_3_o), .serial_line_3_oe_n_o(serial_line_3_oe_n_o),
  .flash_reset_n_o(flash_reset_n_o)
);
`default_nettype wire

// >>> test/xipr_flash_model.sv
// behavioural serial flash: direct-execute state, protocol, reset commands
// assumes it only listens; the host block reads nothing back
`timescale 1ns/10ps
`default_nettype none

module xipr_flash_model (
  input  wire logic        sclk_i,
  input  wire logic        select_n_i,
  input  wire logic        line0_i,
  input  wire logic        line3_i,
  input  wire logic        reset_n_i,
  input  wire logic        pg_i,
  input  wire logic        nv_xip_i,
  input  wire logic [1:0]  nv_proto_i,
  output logic             xip_o,
  output logic [1:0]       proto_o,
  output logic [31:0]      len_log_o,
  output logic [3:0]       sw_rst_o,
  output logic             err_o
);
  int         cnt;
  int         step;
  logic       ones0;
  logic       ones03;
  logic       armed;
  logic [7:0] sh;
  realtime    t_up;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  initial begin
    len_log_o = 32'h0;
    sw_rst_o = 4'h0;
    err_o = 1'b0;
    t_up = 0.0;
  end

  // supply up or pin released: back to the power-up configuration
  always @(posedge pg_i or posedge reset_n_i) begin
    xip_o = nv_xip_i;
    proto_o = nv_proto_i;
    armed = 1'b0;
    step = 0;
  end

  // a pin reset while selected is flagged as an error
  always @(negedge reset_n_i) begin
    if (select_n_i !== 1'b1) err_o = 1'b1;
  end

  // burst start, gap since the last burst
  always @(negedge select_n_i) begin
    cnt = 0;
    ones0 = 1'b1;
    ones03 = 1'b1;
    if ($realtime - t_up < 50.0) err_o = 1'b1;
  end

  // lines 1 and 2 are not modelled at all, so they cannot matter
  always @(posedge sclk_i) begin
    if (select_n_i === 1'b0) begin
      cnt++;
      sh = {sh[6:0], line0_i};
      ones0 = ones0 & line0_i;
      ones03 = ones03 & line0_i & line3_i;
    end
  end

  // burst end: confirm bit, rescue steps, byte commands
  always @(posedge select_n_i) begin
    t_up = $realtime;
    if (pg_i === 1'b1 && cnt > 0) begin
      len_log_o = {len_log_o[23:0], cnt[7:0]};
      if (xip_o && ones0 && cnt == (proto_o == xipr_pkg::PROTO_QUAD ? 7 :
          (proto_o == xipr_pkg::PROTO_DUAL ? 13 : 25))) xip_o = 1'b0;
      if (ones03 && cnt == 7) step = 1;
      else if (ones03 && cnt == 13 && step == 1) step = 2;
      else if (ones03 && cnt == 25 && step == 2) step = 3;
      else if (ones03 && cnt == 8 && step == 3) begin
        proto_o = xipr_pkg::PROTO_SINGLE;
        xip_o = 1'b0;
        step = 0;
      end else step = 0;
      if (!xip_o && cnt == 8) begin
        if (armed && sh == xipr_pkg::CMD_RESET_APPLY) sw_rst_o = sw_rst_o + 4'h1;
        armed = (sh == xipr_pkg::CMD_RESET_ARM);
      end
    end
  end
endmodule
`default_nettype wire

// >>> test/tb.sv
// testbench for the direct-execute exit and rescue host sequencer
// assumes xipr_flash_model on the link and the bound checker
`timescale 1ns/10ps
`default_nettype none

module tb;
  logic        sys_clk = 1'b0;
  logic        link_clk = 1'b0;
  logic        srst = 1'b1;
  logic        start = 1'b0;
  logic [1:0]  op = 2'h0;
  logic [1:0]  proto = 2'h0;
  logic        hw_avail = 1'b1;
  logic        pg = 1'b0;
  logic        nv_xip = 1'b1;
  logic [1:0]  nv_proto = 2'h2;
  logic        busy, done, ok, sclk, sel_n, l0, l0_oe_n, l3, l3_oe_n, rst_n, direct_execute_mode, err;
  logic [1:0]  f_proto;
  logic [31:0] len_log;
  logic [3:0]  swr;
  int          error_cnt = 0;
  int          n_tests = 0;

  // ---------------------------------------------------------------
  // clocks and instances
  // ---------------------------------------------------------------
  always #25 sys_clk = ~sys_clk;

  // link clock, phase unrelated to the system clock
  initial begin
    #7;
    forever #16 link_clk = ~link_clk;
  end

  xipr_host_seq i_dut (.sys_clk_i(sys_clk), .srst_i(srst), .link_clk_i(link_clk),
    .start_i(start), .op_i(op), .proto_i(proto), .hw_reset_avail_i(hw_avail),
    .power_good_i(pg), .busy_o(busy), .done_o(done), .access_ok_o(ok),
    .flash_sclk_o(sclk), .flash_select_n_o(sel_n), .serial_line_0_o(l0),
    .serial_line_0_oe_n_o(l0_oe_n), .serial_line_3_o(l3), .serial_line_3_oe_n_o(l3_oe_n),
    .flash_reset_n_o(rst_n));

  xipr_flash_model i_flash (.sclk_i(sclk), .select_n_i(sel_n), .line0_i(l0), .line3_i(l3),
    .reset_n_i(rst_n), .pg_i(pg), .nv_xip_i(nv_xip), .nv_proto_i(nv_proto), .xip_o(direct_execute_mode),
    .proto_o(f_proto), .len_log_o(len_log), .sw_rst_o(swr), .err_o(err));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("comparisons=%0d mismatches=%0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // one order; poke sends a second start while busy, which must be ignored
  task automatic order(input logic [1:0] o, input logic [1:0] p, input logic poke);
    int i;
    @(negedge sys_clk);
    op = o;
    proto = p;
    start = 1'b1;
    @(negedge sys_clk);
    start = 1'b0;
    if (poke) begin
      repeat (20) @(negedge sys_clk);
      op = xipr_pkg::OP_FORCE_EXIT;
      start = 1'b1;
      @(negedge sys_clk);
      start = 1'b0;
    end
    for (i = 0; i < 9000 && done !== 1'b1; i++) begin
      @(negedge sys_clk);
    end
    if (done !== 1'b1) begin
      error_cnt++;
      $display("MISMATCH t=%0t done=%h exp=%h", $time, done, 1'b1);
      summarize();
    end
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_power();
    nv_proto = xipr_pkg::PROTO_QUAD;
    fork
      order(xipr_pkg::OP_FORCE_EXIT, xipr_pkg::PROTO_QUAD, 1'b0);
      begin
        repeat (200) @(negedge sys_clk);
        chk(len_log, 32'h0);
        chk(32'(ok), 32'h0);
        pg = 1'b1;
      end
    join
    chk(len_log, 32'h0007_0808);
    chk(32'({direct_execute_mode, ok}), 32'h1);
    $display("test power-up and quad exit done");
  endtask

  task automatic t_exit();
    logic [1:0] ps [3] = '{xipr_pkg::PROTO_QUAD, xipr_pkg::PROTO_DUAL, xipr_pkg::PROTO_SINGLE};
    logic [7:0] ls [3] = '{8'h07, 8'h0D, 8'h19};
    for (int i = 0; i < 3; i++) begin
      nv_proto = ps[i];
      order(xipr_pkg::OP_HW_RESET, 2'h0, 1'b0);
      chk(32'({direct_execute_mode, f_proto}), 32'({1'b1, ps[i]}));
      order(xipr_pkg::OP_FORCE_EXIT, ps[i], 1'b0);
      chk(32'(len_log[23:0]), 32'({ls[i], 16'h0808}));
      chk(32'(direct_execute_mode), 32'h0);
    end
    $display("test forced exit per protocol done");
  endtask

  task automatic t_fallback();
    nv_proto = xipr_pkg::PROTO_QUAD;
    order(xipr_pkg::OP_HW_RESET, 2'h0, 1'b0);
    hw_avail = 1'b0;
    order(xipr_pkg::OP_HW_RESET, xipr_pkg::PROTO_QUAD, 1'b0);
    chk(32'(len_log[23:0]), 32'h07_0808);
    chk(32'(direct_execute_mode), 32'h0);
    hw_avail = 1'b1;
    $display("test pin reset fallback done");
  endtask

  task automatic t_rescue();
    order(xipr_pkg::OP_HW_RESET, 2'h0, 1'b0);
    order(xipr_pkg::OP_RESCUE, 2'h0, 1'b1);
    chk(len_log, 32'h070D_1908);
    chk(32'({direct_execute_mode, f_proto}), 32'({1'b0, xipr_pkg::PROTO_SINGLE}));
    $display("test rescue sequence done");
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
    srst = 1'b0;
    t_power();
    t_exit();
    t_fallback();
    t_rescue();
    chk(32'(err), 32'h0);
    chk(32'(swr), 32'h5);
    summarize();
  end
endmodule
`default_nettype wire
